//--- logic/shp_regs.svh
// Constants of the SRAM-style host port: address map, reset values, timing
`ifndef SHP_REGS_SVH
`define SHP_REGS_SVH

// Word addresses on the 7-bit port (A[7:1])
`define SHP_ADDR_RX_DATA    7'h00
`define SHP_ADDR_TX_DATA    7'h10
`define SHP_ADDR_BYTE_TEST  7'h32
`define SHP_ADDR_IRQ_CFG    7'h2c
`define SHP_ADDR_INT_STS    7'h2e
`define SHP_ADDR_INT_EN     7'h2d

// Field positions inside the interrupt configuration word
`define SHP_IRQ_CFG_TYPE    0
`define SHP_IRQ_CFG_POL     4
`define SHP_IRQ_CFG_EN      8

// Reset values
`define SHP_BYTE_TEST_VAL   32'h87654321
`define SHP_IRQ_CFG_RST     32'h00000000
`define SHP_INT_EN_RST      32'h00000000

// FIFO-select window: address bits kept below A[3]
`define SHP_FIFO_ADDR_BITS  2
`define SHP_FIFO_TX_BIT     1

// Read data latency, in reference clocks after strobe seen
`define SHP_RD_LATENCY      1

// Clocks after reset release before the width strap is taken
`define SHP_STRAP_SETTLE    2'h2

`endif

//--- logic/shp_pkg.sv
// Types shared by the SRAM-style host port modules
package shp_pkg;

   typedef enum logic [1:0] {
      SHP_TGT_REG,
      SHP_TGT_RXF,
      SHP_TGT_TXF,
      SHP_TGT_NONE
   } shp_target_t;

   typedef struct packed {
      logic        cs;
      logic        rd;
      logic        wr;
      logic        fifo_sel;
      logic [6:0]  addr;
      logic [31:0] data;
   } shp_pins_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      shp_target_t target;
      logic [6:0]  addr;
      logic [31:0] data;
   } shp_access_t;

endpackage

//--- logic/shp_sync.sv
// Two-stage synchroniser for a bundle of host pin levels
`timescale 1ns/10ps

module shp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk, // Reference clock
   input  wire logic             rst,     // Async reset, active high
   input  wire logic [WIDTH-1:0] d_in,    // Asynchronous levels
   output logic      [WIDTH-1:0] d_out    // Synchronised levels
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign d_out = sync_reg;

endmodule

//--- logic/shp_width.sv
// Pairs 16-bit halves into 32-bit words and splits words on reads
`timescale 1ns/10ps
`include "shp_regs.svh"

module shp_width (
   input  wire logic        ref_clk,    // Reference clock
   input  wire logic        rst,        // Async reset, active high
   input  wire logic        mode32,     // Latched bus width, 1 = 32-bit
   input  wire logic        swap,       // Byte order swap for big-endian hosts
   input  wire logic        wr_stb,     // One-cycle write event
   input  wire logic        half_sel,   // Address bit A[1]: upper half
   input  wire logic [31:0] wr_pins,    // Synchronised data lines
   input  wire logic [31:0] rd_word,    // Internal word being read
   output logic             word_valid, // Full internal word assembled
   output logic      [31:0] word_data,  // Assembled internal word
   output logic      [31:0] rd_pins     // Data for the pins
);

   logic [15:0] low_reg;
   logic [31:0] wr_word;
   logic [31:0] rd_ord;

   function automatic logic [31:0] order(input logic [31:0] w, input logic s);
      order = s ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
   endfunction

   // Low half is held until the upper half completes the word
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         low_reg <= 16'h0000;
      end else if (wr_stb && !mode32 && !half_sel) begin
         low_reg <= wr_pins[15:0];
      end
   end

   assign wr_word    = mode32 ? wr_pins : {wr_pins[15:0], low_reg};
   assign word_valid = wr_stb && (mode32 || half_sel);
   assign word_data  = order(wr_word, swap);
   assign rd_ord     = order(rd_word, swap);
   assign rd_pins    = mode32 ? rd_ord :
                       {16'h0000, half_sel ? rd_ord[31:16] : rd_ord[15:0]};

endmodule

//--- logic/shp_top.sv
// SRAM-style host port: pin decode, width strap, wake, data FIFO ports and irq pin
`timescale 1ns/10ps
`include "shp_regs.svh"

module shp_top #(
   parameter int NSRC = 8
) (
   input  wire logic            ref_clk,         // 25 MHz reference clock
   input  wire logic            rst,             // Async reset, active high
   input  wire logic            chip_select_n,   // Chip select pin, low active
   input  wire logic            read_strobe_n,   // Read strobe pin, low active
   input  wire logic            write_strobe_n,  // Write strobe pin, low active
   input  wire logic            fifo_sel,        // FIFO select pin
   input  wire logic [6:0]      addr,            // Word address A[7:1]
   input  wire logic [31:0]     data_in,         // Data lines as seen at the pins
   output logic      [31:0]     data_out,        // Data lines driven value
   output logic      [31:0]     data_oe,         // Data line enables, high drives
   output logic                 pulldown_hi_en,  // Upper data pull-downs enabled
   input  wire logic            bus_width_strap, // Width strap pin
   input  wire logic            low_power,       // Device is in reduced power
   output logic                 wake_req,        // One-cycle wake request
   output logic                 mode32,          // Latched bus width
   input  wire logic [31:0]     rx_word,         // Receive FIFO head word
   output logic                 rx_pop,          // One-cycle receive FIFO pop
   output logic                 tx_push,         // One-cycle transmit FIFO push
   output logic      [31:0]     tx_word,         // Transmit FIFO word
   output logic                 reg_wr,          // One-cycle register write
   output logic                 reg_rd,          // One-cycle register read
   output logic      [6:0]      reg_addr,        // Register word address
   output logic      [31:0]     reg_wdata,       // Register write word
   input  wire logic [31:0]     reg_rdata,       // Register read word
   input  wire logic [NSRC-1:0] irq_sources,     // Interrupt event levels
   output logic                 irq_out,         // Interrupt pin value
   output logic                 irq_oe,          // Interrupt pin enable
   output logic                 writes_armed     // A first read has unlocked writes
);

   // ****************************************
   // Pin synchronisation
   // ****************************************
   shp_pkg::shp_pins_t pins_raw;
   shp_pkg::shp_pins_t pins_s;

   assign pins_raw = '{cs: ~chip_select_n, rd: ~read_strobe_n, wr: ~write_strobe_n,
                       fifo_sel: fifo_sel, addr: addr, data: data_in};

   shp_sync #(.WIDTH($bits(shp_pkg::shp_pins_t))) u_pins (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d_in    (pins_raw),
      .d_out   (pins_s)
   );

   logic strap_s;

   shp_sync #(.WIDTH(1)) u_strap (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d_in    (bus_width_strap),
      .d_out   (strap_s)
   );

   // ****************************************
   // Strobe qualification and decode
   // ****************************************
   logic        rd_q_reg;
   logic        wr_q_reg;
   logic        rd_act;
   logic        wr_act;
   logic        rd_rise;
   logic        wr_fall;
   logic [6:0]  eff_addr;
   shp_pkg::shp_target_t tgt;

   assign rd_act = pins_s.cs && pins_s.rd;
   assign wr_act = pins_s.cs && pins_s.wr;
   assign rd_rise = rd_act && !rd_q_reg;
   // Write data is taken at strobe release, when the host data is settled
   assign wr_fall = !wr_act && wr_q_reg;

   function automatic shp_pkg::shp_target_t decode(input logic [6:0] a, input logic fs);
      if (fs) begin
         decode = a[`SHP_FIFO_TX_BIT] ? shp_pkg::SHP_TGT_TXF : shp_pkg::SHP_TGT_RXF;
      end else if (a[6:3] == 4'(`SHP_ADDR_RX_DATA >> 3)) begin
         decode = shp_pkg::SHP_TGT_RXF;
      end else if (a[6:3] == 4'(`SHP_ADDR_TX_DATA >> 3)) begin
         decode = shp_pkg::SHP_TGT_TXF;
      end else begin
         decode = shp_pkg::SHP_TGT_REG;
      end
   endfunction

   // FIFO select masks the upper address bits entirely
   assign eff_addr = pins_s.fifo_sel ?
                     {5'h00, pins_s.addr[`SHP_FIFO_ADDR_BITS-1:0]} : pins_s.addr;
   assign tgt      = decode(eff_addr, pins_s.fifo_sel);

   // Target flags: is_rxf and is_reg feed the read mux, all three feed the pulses
   logic is_rxf;
   logic is_txf;
   logic is_reg;

   assign is_rxf = (tgt == shp_pkg::SHP_TGT_RXF);
   assign is_txf = (tgt == shp_pkg::SHP_TGT_TXF);
   assign is_reg = (tgt == shp_pkg::SHP_TGT_REG);

   // ****************************************
   // Strap latch and write arming
   // ****************************************
   logic       strap_done_reg;
   logic       mode32_reg;
   logic       armed_reg;
   logic [1:0] strap_age_reg;

   // Synchroniser restarts from zero, so the strap is taken once it has refilled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strap_age_reg  <= 2'h0;
         strap_done_reg <= 1'b0;
         mode32_reg     <= 1'b0;
      end else if (!strap_done_reg) begin
         if (strap_age_reg == `SHP_STRAP_SETTLE) begin
            strap_done_reg <= 1'b1;
            mode32_reg     <= strap_s;
         end else begin
            strap_age_reg <= strap_age_reg + 2'h1;
         end
      end
   end

   // Writes before the first read are dropped; low power re-locks them
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         armed_reg <= 1'b0;
      end else if (rd_rise) begin
         armed_reg <= 1'b1;
      end else if (low_power) begin
         armed_reg <= 1'b0;
      end
   end

   // ****************************************
   // Width conversion
   // ****************************************
   logic        word_valid;
   logic [31:0] word_data;
   logic [31:0] rd_pins;
   logic [31:0] rd_word;
   logic        swap_reg;

   assign rd_word = is_rxf ? rx_word :
                    is_reg ? reg_rdata : 32'h00000000;

   shp_width u_width (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .mode32     (mode32_reg),
      .swap       (swap_reg),
      .wr_stb     (wr_fall && armed_reg),
      .half_sel   (eff_addr[0]),
      .wr_pins    (pins_s.data),
      .rd_word    (rd_word),
      .word_valid (word_valid),
      .word_data  (word_data),
      .rd_pins    (rd_pins)
   );

   // ****************************************
   // Byte order and interrupt configuration
   // ****************************************
   logic [31:0]     irq_cfg_reg;
   logic [NSRC-1:0] int_en_reg;
   logic            cfg_wr;
   logic            irq_req;
   logic            irq_level;

   assign cfg_wr = word_valid && is_reg;

   // A 32-bit host seeing swapped test pattern writes it back to flip order
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         swap_reg    <= 1'b0;
         irq_cfg_reg <= `SHP_IRQ_CFG_RST;
         int_en_reg  <= NSRC'(`SHP_INT_EN_RST);
      end else if (cfg_wr) begin
         if (eff_addr == `SHP_ADDR_BYTE_TEST) begin
            swap_reg <= (word_data != `SHP_BYTE_TEST_VAL) ? ~swap_reg : swap_reg;
         end
         if (eff_addr == `SHP_ADDR_IRQ_CFG) begin
            irq_cfg_reg <= word_data;
         end
         if (eff_addr == `SHP_ADDR_INT_EN) begin
            int_en_reg <= word_data[NSRC-1:0];
         end
      end
   end

   assign irq_req   = |(irq_sources & int_en_reg) && irq_cfg_reg[`SHP_IRQ_CFG_EN];
   assign irq_level = irq_req ~^ irq_cfg_reg[`SHP_IRQ_CFG_POL];

   // ****************************************
   // Output registers
   // ****************************************
   logic [31:0] oe_width;
   logic [31:0] drive_oe;
   logic        last_half;
   logic        wake_next;
   logic        rx_pop_next;
   logic        tx_push_next;
   logic        reg_rd_next;
   logic        irq_oe_next;

   // Upper lines stay released in 16-bit mode
   assign oe_width     = mode32_reg ? 32'hffffffff : 32'h0000ffff;
   assign drive_oe     = rd_act ? oe_width : 32'h00000000;
   // A 16-bit host completes a word with its upper half
   assign last_half    = mode32_reg || eff_addr[0];
   assign wake_next    = low_power && wr_act && !wr_q_reg;
   // Pop at the start of the last half's read so both halves read the same word
   assign rx_pop_next  = rd_rise && is_rxf && last_half;
   assign tx_push_next = word_valid && is_txf;
   assign reg_rd_next  = rd_rise && is_reg;
   // Open-drain drives only the active-low level
   assign irq_oe_next  = irq_cfg_reg[`SHP_IRQ_CFG_TYPE] || (irq_level == 1'b0);

   // ****************************************
   // Strobe history, read data and width pin registers
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_q_reg       <= 1'b0;
         wr_q_reg       <= 1'b0;
         data_out       <= 32'h00000000;
         data_oe        <= 32'h00000000;
         pulldown_hi_en <= 1'b1;
         mode32         <= 1'b0;
      end else begin
         rd_q_reg       <= rd_act;
         wr_q_reg       <= wr_act;
         data_out       <= rd_pins;
         data_oe        <= drive_oe;
         pulldown_hi_en <= !mode32_reg;
         mode32         <= mode32_reg;
      end
   end

   // ****************************************
   // Access pulses
   // ****************************************
   // Address and data follow every clock; only the pulses qualify them
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake_req     <= 1'b0;
         rx_pop       <= 1'b0;
         tx_push      <= 1'b0;
         tx_word      <= 32'h00000000;
         reg_wr       <= 1'b0;
         reg_rd       <= 1'b0;
         reg_addr     <= 7'h00;
         reg_wdata    <= 32'h00000000;
         writes_armed <= 1'b0;
      end else begin
         wake_req     <= wake_next;
         rx_pop       <= rx_pop_next;
         tx_push      <= tx_push_next;
         tx_word      <= word_data;
         reg_wr       <= cfg_wr;
         reg_rd       <= reg_rd_next;
         reg_addr     <= eff_addr;
         reg_wdata    <= word_data;
         writes_armed <= armed_reg;
      end
   end

   // ****************************************
   // Interrupt pin
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_out <= 1'b0;
         irq_oe  <= 1'b0;
      end else begin
         irq_out <= irq_level;
         irq_oe  <= irq_oe_next;
      end
   end

endmodule

//--- sim/shp_props.sv
// Concurrent checks on the host port pins and pulses
`timescale 1ns/10ps
module shp_props (
   input wire logic        ref_clk,        // Clock
   input wire logic        rst,            // Reset
   input wire logic        chip_select_n,  // Chip select
   input wire logic        read_strobe_n,  // Read strobe
   input wire logic        write_strobe_n, // Write strobe
   input wire logic        fifo_sel,       // FIFO select
   input wire logic [6:0]  addr,           // Word address
   input wire logic [31:0] data_oe,        // Data enables
   input wire logic        pulldown_hi_en, // Upper pull-downs
   input wire logic        low_power,      // Reduced power
   input wire logic        wake_req,       // Wake pulse
   input wire logic        mode32,         // Bus width
   input wire logic        rx_pop,         // RX pop
   input wire logic        tx_push,        // TX push
   input wire logic        reg_wr,         // Register write
   input wire logic        writes_armed    // Writes unlocked
);
   // ***********
   // Pin history
   // ***********
   logic       rd_p;
   logic       wr_p;
   logic       wr_ok;
   logic [3:0] rd_age_reg;
   logic [3:0] wr_age_reg;
   logic [2:0] up_reg;
   assign rd_p  = !chip_select_n && !read_strobe_n;
   assign wr_p  = !chip_select_n && !write_strobe_n;
   assign wr_ok = writes_armed && !low_power && (mode32 || addr[0]);
   // Pins are asynchronous, so pulses are judged against a window of ages
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_age_reg <= 4'hf;
         wr_age_reg <= 4'hf;
         up_reg     <= 3'h0;
      end else begin
         rd_age_reg <= rd_p ? 4'h0 : rd_age_reg + {3'h0, rd_age_reg != 4'hf};
         wr_age_reg <= wr_p ? 4'h0 : wr_age_reg + {3'h0, wr_age_reg != 4'hf};
         up_reg     <= up_reg + {2'h0, up_reg != 3'h7};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_rd_go;
      $rose(rd_p);
   endsequence
   sequence s_wr_done;
      $fell(wr_p) && wr_ok;
   endsequence
   AST_RD_OE: assert property (s_rd_go |-> ##[2:4] (data_oe != 32'h0))
      else $error("data lines not driven after read");
   AST_OE_HOLD: assert property ((data_oe != 32'h0) |-> rd_age_reg <= 4'h5)
      else $error("data lines driven without read");
   AST_OE_WIDTH: assert property ((data_oe != 32'h0) |->
      data_oe == (mode32 ? 32'hffffffff : 32'h0000ffff))
      else $error("data enables do not match width");
   AST_PD: assert property ($stable(mode32) |-> pulldown_hi_en == !mode32)
      else $error("pull-down state wrong for width");
   AST_LATCH: assert property ($changed(mode32) |-> up_reg < 3'h5)
      else $error("width changed after reset release");
   AST_WR_PULSE: assert property (s_wr_done |-> ##[2:4] (tx_push || reg_wr))
      else $error("write not forwarded");
   AST_WR_CAUSE: assert property ((tx_push || reg_wr) |->
      wr_age_reg >= 4'h1 && wr_age_reg <= 4'h6)
      else $error("write pulse without write strobe");
   AST_WR_LOCK: assert property ((tx_push || reg_wr) |->
      writes_armed || $past(writes_armed))
      else $error("write forwarded while locked");
   AST_TX_SEL: assert property (s_wr_done ##0 (fifo_sel && addr[1]) |->
      ##[2:4] tx_push)
      else $error("FIFO select write missed tx push");
   AST_RX_SEL: assert property (s_rd_go ##0 (fifo_sel && !addr[1] &&
      (mode32 || addr[0])) |-> ##[2:4] rx_pop)
      else $error("FIFO select read missed rx pop");
   AST_WAKE: assert property ($rose(wr_p) && low_power |-> ##[1:12] wake_req)
      else $error("no wake request");
endmodule
bind shp_top shp_props i_props (
   .ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n),
   .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
   .fifo_sel(fifo_sel), .addr(addr), .data_oe(data_oe),
   .pulldown_hi_en(pulldown_hi_en), .low_power(low_power), .wake_req(wake_req),
   .mode32(mode32), .rx_pop(rx_pop), .tx_push(tx_push), .reg_wr(reg_wr),
   .writes_armed(writes_armed)
);

//--- sim/shp_host_model.sv
// Host processor model driving the SRAM-style pins
`timescale 1ns/10ps
module shp_host_model (
   input  wire logic        ref_clk,        // Clock
   input  wire logic        w32,            // Host drives all 32 lines
   input  wire logic [31:0] data_out,       // Port driven value
   input  wire logic [31:0] data_oe,        // Port enables
   input  wire logic        pulldown_hi_en, // Upper pull-downs on
   output logic             chip_select_n,  // Chip select
   output logic             read_strobe_n,  // Read strobe
   output logic             write_strobe_n, // Write strobe
   output logic             fifo_sel,       // FIFO select
   output logic      [6:0]  addr,           // Word address
   output logic      [31:0] data_in         // Resolved data lines
);
   logic [31:0] hdata_reg;
   logic [31:0] last_reg;
   logic [31:0] hmask;
   logic [31:0] pd;
   logic        hdrv_reg;
   initial begin
      chip_select_n  = 1'b1;
      read_strobe_n  = 1'b1;
      write_strobe_n = 1'b1;
      fifo_sel       = 1'b0;
      addr           = 7'h00;
      hdata_reg      = 32'h0;
      hdrv_reg       = 1'b0;
      last_reg       = 32'h0;
   end
   // Floating lines flip every cycle so stale data never passes as valid
   assign hmask   = hdrv_reg ? (w32 ? 32'hffffffff : 32'h0000ffff) : 32'h0;
   assign pd      = pulldown_hi_en ? 32'hffff0000 : 32'h0;
   assign data_in = (data_oe & data_out) | (~data_oe & hmask & hdata_reg)
                  | (~data_oe & ~hmask & ~pd & ~last_reg);
   always @(posedge ref_clk) last_reg <= data_in;
   task automatic acc(input logic cs, input logic wr, input logic fs,
                      input logic [6:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge ref_clk);
      #1;
      chip_select_n  = ~cs;
      fifo_sel       = fs;
      addr           = a;
      read_strobe_n  = wr;
      write_strobe_n = ~wr;
      hdata_reg      = d;
      hdrv_reg       = wr;
      repeat (6) @(posedge ref_clk);
      q = data_in;
      #1;
      chip_select_n  = 1'b1;
      read_strobe_n  = 1'b1;
      write_strobe_n = 1'b1;
      // Data held past the strobe: the port takes it at the synced strobe end
      repeat (3) @(posedge ref_clk);
      #1;
      hdrv_reg = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the SRAM-style host port
`timescale 1ns/10ps
module tb_top;
   logic        ref_clk, rst, bus_width_strap, low_power;
   logic [31:0] rx_word, reg_rdata, q, tx_w, rw_d;
   logic [7:0]  irq_sources;
   logic [6:0]  rw_a;
   logic [31:0] n_tx = 32'h0, n_rx = 32'h0, n_rw = 32'h0, n_rr = 32'h0, n_wk = 32'h0;
   int          mismatches = 0, checks = 0;
   wire logic        chip_select_n, read_strobe_n, write_strobe_n, fifo_sel;
   wire logic [6:0]  addr, reg_addr;
   wire logic [31:0] data_in, data_out, data_oe, tx_word, reg_wdata;
   wire logic        pulldown_hi_en, wake_req, mode32, rx_pop, tx_push;
   wire logic        reg_wr, reg_rd, irq_out, irq_oe, writes_armed;
   // Register file stand-in: byte test word at both halves, else a tagged address
   assign reg_rdata = (reg_addr[6:1] == 6'h19) ? 32'h87654321 : {25'h181bc00, reg_addr};
   shp_top #(.NSRC(8)) i_dut (.ref_clk, .rst, .chip_select_n, .read_strobe_n,
      .write_strobe_n, .fifo_sel, .addr, .data_in, .data_out, .data_oe,
      .pulldown_hi_en, .bus_width_strap, .low_power, .wake_req, .mode32, .rx_word,
      .rx_pop, .tx_push, .tx_word, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .irq_sources, .irq_out, .irq_oe, .writes_armed);
   shp_host_model i_host (.ref_clk, .w32(bus_width_strap), .data_out, .data_oe,
      .pulldown_hi_en, .chip_select_n, .read_strobe_n, .write_strobe_n, .fifo_sel,
      .addr, .data_in);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Pulses are caught here since the host tasks block through them
   always @(posedge ref_clk) begin
      if (tx_push) begin
         n_tx++;
         tx_w = tx_word;
      end
      if (reg_wr) begin
         n_rw++;
         rw_a = reg_addr;
         rw_d = reg_wdata;
      end
      if (rx_pop) n_rx++;
      if (reg_rd) n_rr++;
      if (wake_req) n_wk++;
   end
   // *****
   // Tasks
   // *****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic clr();
      {n_tx, n_rx, n_rw, n_rr, n_wk} = '0;
   endtask
   task automatic do_reset(input logic strap);
      rst = 1'b1;
      bus_width_strap = strap;
      repeat (4) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      clr();
   endtask
   task automatic t_boot32();
      do_reset(1'b1);
      chk(32'(mode32), 32'h1);
      chk(32'(pulldown_hi_en), 32'h0);
      i_host.acc(1'b1, 1'b1, 1'b1, 7'h02, 32'h11111111, q);
      chk(n_tx, 32'h0);
      i_host.acc(1'b1, 1'b0, 1'b0, 7'h32, 32'h0, q);
      chk(q, 32'h87654321);
      chk(32'(writes_armed), 32'h1);
      $display("t_boot32 done");
   endtask
   task automatic t_fifo32();
      clr();
      rx_word = 32'ha5c30f96;
      i_host.acc(1'b1, 1'b1, 1'b1, 7'h7e, 32'h3c5a9617, q);
      chk(n_tx, 32'h1);
      chk(tx_w, 32'h3c5a9617);
      i_host.acc(1'b1, 1'b0, 1'b1, 7'h7c, 32'h0, q);
      chk(n_rx, 32'h1);
      chk(q, 32'ha5c30f96);
      $display("t_fifo32 done");
   endtask
   task automatic t_reg();
      clr();
      i_host.acc(1'b1, 1'b1, 1'b0, 7'h2d, 32'h000000ff, q);
      i_host.acc(1'b1, 1'b1, 1'b0, 7'h2c, 32'h00000111, q);
      chk(n_rw, 32'h2);
      chk({25'h0, rw_a}, 32'h2c);
      chk(rw_d, 32'h111);
      i_host.acc(1'b1, 1'b0, 1'b0, 7'h50, 32'h0, q);
      chk(n_rr, 32'h1);
      chk(q, 32'hc0de0050);
      irq_sources = 8'h01;
      repeat (8) @(posedge ref_clk);
      chk({irq_oe, irq_out}, 32'h3);
      i_host.acc(1'b1, 1'b1, 1'b0, 7'h2c, 32'h00000101, q);
      repeat (8) @(posedge ref_clk);
      chk({irq_oe, irq_out}, 32'h2);
      i_host.acc(1'b1, 1'b1, 1'b0, 7'h2c, 32'h00000100, q);
      repeat (8) @(posedge ref_clk);
      chk({irq_oe, irq_out}, 32'h2);
      #1;
      irq_sources = 8'h00;
      repeat (8) @(posedge ref_clk);
      chk({irq_oe, irq_out}, 32'h1);
      $display("t_reg done");
   endtask
   task automatic t_nocs();
      clr();
      i_host.acc(1'b0, 1'b0, 1'b0, 7'h50, 32'h0, q);
      i_host.acc(1'b0, 1'b1, 1'b1, 7'h12, 32'h0badf00d, q);
      chk(n_rr + n_rw + n_tx, 32'h0);
      $display("t_nocs done");
   endtask
   task automatic t_wake();
      clr();
      low_power = 1'b1;
      i_host.acc(1'b1, 1'b1, 1'b0, 7'h32, 32'h87654321, q);
      chk(n_wk, 32'h1);
      chk(n_rw, 32'h0);
      low_power = 1'b0;
      i_host.acc(1'b1, 1'b0, 1'b0, 7'h32, 32'h0, q);
      chk(32'(writes_armed), 32'h1);
      $display("t_wake done");
   endtask
   task automatic t_16();
      do_reset(1'b0);
      chk({mode32, pulldown_hi_en}, 32'h1);
      i_host.acc(1'b1, 1'b0, 1'b0, 7'h32, 32'h0, q);
      chk({16'h0, q[15:0]}, 32'h4321);
      i_host.acc(1'b1, 1'b0, 1'b0, 7'h33, 32'h0, q);
      chk({16'h0, q[15:0]}, 32'h8765);
      i_host.acc(1'b1, 1'b1, 1'b1, 7'h02, 32'h5678, q);
      chk(n_tx, 32'h0);
      i_host.acc(1'b1, 1'b1, 1'b1, 7'h03, 32'h1234, q);
      chk(tx_w, 32'h12345678);
      i_host.acc(1'b1, 1'b0, 1'b1, 7'h00, 32'h0, q);
      chk(n_rx, 32'h0);
      i_host.acc(1'b1, 1'b0, 1'b1, 7'h01, 32'h0, q);
      chk({n_rx[15:0], q[15:0]}, {16'h1, rx_word[31:16]});
      $display("t_16 done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #(40 * 6000);
      mismatches++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      bus_width_strap = 1'b1;
      low_power = 1'b0;
      rx_word = 32'h0;
      irq_sources = 8'h00;
      t_boot32();
      t_fifo32();
      t_reg();
      t_nocs();
      t_wake();
      t_16();
      summarize();
   end
endmodule
